// File: hdl/udc_pkg.sv
// constants and types shared by the usb dma channel engine
package udc_pkg;
  localparam int NCH = 4;
  localparam int CW = 2;
  localparam logic [31:0] NUM_CH = 32'h0000_0004;
  localparam logic [7:0] REG_SEL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_INT = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_NUM = 8'h1C;
  localparam int CFG_IE = 8;
  localparam int CFG_EN = 9;
  localparam int CTL_EN = 0;
  localparam int CTL_DIS = 1;
  localparam int CTL_IEN = 2;
  localparam int CTL_IDIS = 3;
  localparam int STAT_ERR = 0;
  localparam logic DIR_RX = 1'h0;
  localparam logic DIR_TX = 1'h1;
  localparam logic MODE_SINGLE = 1'h0;
  localparam logic MODE_MULTI = 1'h1;
  localparam logic [1:0] BURST_NONE = 2'h0;
  localparam logic [1:0] BURST_4 = 2'h1;
  localparam logic [1:0] BURST_8 = 2'h2;
  localparam logic [1:0] BURST_16 = 2'h3;
  localparam logic [6:0] MAX_PKT = 7'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef struct packed {
    logic [3:0] ep;
    logic [1:0] burst;
    logic mode;
    logic dir;
  } udc_cfg_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } udc_req_type;
endpackage

// File: hdl/udc_axil.sv
// axi4-lite slave front end of the dma register file
`timescale 1ns/1ps
module udc_axil
  import udc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output udc_req_type req_o,
  input wire logic [31:0] rval_i,
  input wire logic rhit_i,
  input wire logic whit_i
);
  logic aw_q, w_q, ar_q;
  logic [7:0] waddr_q, raddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign req_o = '{wr: aw_q && w_q, rd: ar_q, waddr: waddr_q, raddr: raddr_q, wdata: wdata_q, wstrb: wstrb_q};

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      aw_q <= 1'h0;
      awready_o <= 1'h0;
      waddr_q <= 8'h00;
    end else if (awvalid_i && awready_o) begin
      aw_q <= 1'h1;
      awready_o <= 1'h0;
      waddr_q <= awaddr_i;
    end else if (req_o.wr) begin
      aw_q <= 1'h0;
    end else if (!aw_q && !bvalid_o) begin
      awready_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      w_q <= 1'h0;
      wready_o <= 1'h0;
      wdata_q <= RST_WORD;
      wstrb_q <= 4'h0;
    end else if (wvalid_i && wready_o) begin
      w_q <= 1'h1;
      wready_o <= 1'h0;
      wdata_q <= wdata_i;
      wstrb_q <= wstrb_i;
    end else if (req_o.wr) begin
      w_q <= 1'h0;
    end else if (!w_q && !bvalid_o) begin
      wready_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      bvalid_o <= 1'h0;
      bresp_o <= RESP_OKAY;
    end else if (req_o.wr) begin
      bvalid_o <= 1'h1;
      bresp_o <= whit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ar_q <= 1'h0;
      arready_o <= 1'h0;
      raddr_q <= 8'h00;
    end else if (arvalid_i && arready_o) begin
      ar_q <= 1'h1;
      arready_o <= 1'h0;
      raddr_q <= araddr_i;
    end else if (req_o.rd) begin
      ar_q <= 1'h0;
    end else if (!rvalid_o) begin
      arready_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      rvalid_o <= 1'h0;
      rdata_o <= RST_WORD;
      rresp_o <= RESP_OKAY;
    end else if (req_o.rd) begin
      rvalid_o <= 1'h1;
      rdata_o <= rhit_i ? rval_i : RST_WORD;
      rresp_o <= rhit_i ? RESP_OKAY : RESP_SLVERR;
    end else if (rready_i) begin
      rvalid_o <= 1'h0;
    end
  end
endmodule

// File: hdl/udc_chan.sv
// one dma channel: setup, live address and count, flags
`timescale 1ns/1ps
module udc_chan
  import udc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic cfg_wr_i,
  input wire logic addr_wr_i,
  input wire logic cnt_wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic en_set_i,
  input wire logic en_clr_i,
  input wire logic ie_set_i,
  input wire logic ie_clr_i,
  input wire logic err_set_i,
  input wire logic err_clr_i,
  input wire logic step_i,
  output udc_cfg_type cfg_o,
  output logic en_o,
  output logic ie_o,
  output logic err_o,
  output logic [31:0] addr_o,
  output logic [31:0] cnt_o
);
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cfg_o <= '0;
    end else if (cfg_wr_i) begin
      cfg_o <= udc_cfg_type'(wdata_i[7:0]);
    end
  end

  // stop wins over start; last byte stops the channel itself
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      en_o <= 1'h0;
    end else if (en_clr_i || err_set_i || (step_i && cnt_o == 32'h0000_0001)) begin
      en_o <= 1'h0;
    end else if (en_set_i || (cfg_wr_i && wdata_i[CFG_EN])) begin
      en_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ie_o <= 1'h0;
    end else if (ie_clr_i) begin
      ie_o <= 1'h0;
    end else if (ie_set_i || (cfg_wr_i && wdata_i[CFG_IE])) begin
      ie_o <= 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      err_o <= 1'h0;
    end else if (err_set_i) begin
      err_o <= 1'h1;
    end else if (err_clr_i) begin
      err_o <= 1'h0;
    end
  end

  // a software write beats a step in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      addr_o <= RST_WORD;
      cnt_o <= RST_WORD;
    end else begin
      if (addr_wr_i) begin
        addr_o <= wdata_i;
      end else if (step_i) begin
        addr_o <= addr_o + 32'h0000_0001;
      end
      if (cnt_wr_i) begin
        cnt_o <= wdata_i;
      end else if (step_i) begin
        cnt_o <= cnt_o - 32'h0000_0001;
      end
    end
  end
endmodule

// File: hdl/udc_top.sv
// usb endpoint dma engine: registers, channel arbiter and byte mover
// What this block does
// - Channels are picked by zero-based index; channel accesses touch only that channel.
// - Channel address is read source on transmit, write destination on receive.
// - Reading the address gives the live transfer address.
// - A byte count sets how many bytes the channel moves.
// - Reading the count gives the live remaining byte count.
// - Each channel is tied to one endpoint and only moves its FIFO data.
// - Burst setting: none, four, eight or sixteen words on the memory side.
// - Single-packet mode raises one completion interrupt per packet.
// - Multi-packet mode raises one completion interrupt per whole transfer.
// - Receive moves FIFO to memory; transmit moves memory to FIFO.
// - Setup write may arm the channel interrupt at once.
// - Setup write may start the channel at once.
// - Per-channel enable; transfers happen only while enabled.
// - Per-channel disable stops only the selected channel.
// - Per-channel interrupt enable and disable; disabled channels raise nothing.
// - Interrupt status has one bit per channel; reading clears those pending.
// - Multi-packet receive starts only on a full packet, never on short.
// - Per-channel error flag, cleared by writing back the bits read.
// - A register reports the number of channels, zero if absent.
`timescale 1ns/1ps
module udc_top
  import udc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic [3:0] ep_sel_o,
  input wire logic [15:0] ep_rx_avail_i,
  input wire logic [15:0] ep_pkt_full_i,
  input wire logic ep_rx_valid_i,
  input wire logic [7:0] ep_rx_data_i,
  input wire logic ep_rx_last_i,
  output logic ep_rx_ready_o,
  output logic ep_tx_valid_o,
  output logic [7:0] ep_tx_data_o,
  output logic ep_tx_last_o,
  input wire logic ep_tx_ready_i,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic [1:0] mem_burst_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  output logic irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_RX_GET, ST_MEM, ST_TX_PUT} udc_st_type;

  udc_req_type req;
  udc_st_type st_q;
  udc_cfg_type ch_cfg [NCH];
  udc_cfg_type cc;
  logic [31:0] ch_addr [NCH];
  logic [31:0] ch_cnt [NCH];
  logic [NCH-1:0] ch_en, ch_ie, ch_err;
  logic [NCH-1:0] pend_q, pend_nx, set_vec, en_prev_q;
  logic [CW-1:0] sel_q, cur_q, pick;
  logic [6:0] pkt_off_q;
  logic [32:0] wcur, rcur;
  logic [31:0] wval, ccnt;
  logic last_q, go, pkt_end, step, err_set, rd_int;
  logic wr_sel, wr_cfg, wr_addr, wr_cnt, wr_ctl, wr_stat;

  // register view of the selected channel, {hit, data}
  function automatic logic [32:0] rd_val(input logic [7:0] a);
    case (a)
      REG_SEL: rd_val = {1'h1, 30'h0, sel_q};
      REG_CFG: rd_val = {1'h1, 22'h0, ch_en[sel_q], ch_ie[sel_q], ch_cfg[sel_q]};
      REG_ADDR: rd_val = {1'h1, ch_addr[sel_q]};
      REG_CNT: rd_val = {1'h1, ch_cnt[sel_q]};
      REG_CTRL: rd_val = {1'h1, RST_WORD};
      REG_INT: rd_val = {1'h1, 28'h0, pend_q};
      REG_STAT: rd_val = {1'h1, 31'h0, ch_err[sel_q]};
      REG_NUM: rd_val = {1'h1, NUM_CH};
      default: rd_val = {1'h0, RST_WORD};
    endcase
  endfunction

  udc_axil u_axil (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .awaddr_i(s_axi_awaddr_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .bresp_o(s_axi_bresp_o),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .araddr_i(s_axi_araddr_i),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .req_o(req),
    .rval_i(rcur[31:0]),
    .rhit_i(rcur[32]),
    .whit_i(wcur[32])
  );

  // partial writes keep the unselected bytes of the current value
  always_comb begin
    wcur = rd_val(req.waddr);
    rcur = rd_val(req.raddr);
    wval = wcur[31:0];
    for (int b = 0; b < 4; b++) begin
      if (req.wstrb[b]) begin
        wval[8*b +: 8] = req.wdata[8*b +: 8];
      end
    end
  end

  assign wr_sel = req.wr && req.waddr == REG_SEL;
  assign wr_cfg = req.wr && req.waddr == REG_CFG;
  assign wr_addr = req.wr && req.waddr == REG_ADDR;
  assign wr_cnt = req.wr && req.waddr == REG_CNT;
  assign wr_ctl = req.wr && req.waddr == REG_CTRL;
  assign wr_stat = req.wr && req.waddr == REG_STAT;
  assign rd_int = req.rd && req.raddr == REG_INT;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sel_q <= '0;
    end else if (wr_sel) begin
      sel_q <= wval[CW-1:0];
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic me, act;
    assign me = sel_q == CW'(i);
    assign act = cur_q == CW'(i);
    udc_chan u_chan (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .cfg_wr_i(me && wr_cfg),
      .addr_wr_i(me && wr_addr),
      .cnt_wr_i(me && wr_cnt),
      .wdata_i(wval),
      .en_set_i(me && wr_ctl && wval[CTL_EN]),
      .en_clr_i(me && wr_ctl && wval[CTL_DIS]),
      .ie_set_i(me && wr_ctl && wval[CTL_IEN]),
      .ie_clr_i(me && wr_ctl && wval[CTL_IDIS]),
      .err_set_i(act && err_set),
      // a written one clears; the merged read-back must not clear it on a partial write
      .err_clr_i(me && wr_stat && req.wstrb[0] && req.wdata[STAT_ERR]),
      .step_i(act && step),
      .cfg_o(ch_cfg[i]),
      .en_o(ch_en[i]),
      .ie_o(ch_ie[i]),
      .err_o(ch_err[i]),
      .addr_o(ch_addr[i]),
      .cnt_o(ch_cnt[i])
    );
  end

  // lowest ready channel wins; a channel keeps the mover to its packet end
  always_comb begin
    go = 1'h0;
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ch_en[i] && ch_cnt[i] != RST_WORD && (ch_cfg[i].dir == DIR_TX ||
          (ch_cfg[i].mode == MODE_MULTI ? ep_pkt_full_i[ch_cfg[i].ep] : ep_rx_avail_i[ch_cfg[i].ep]))) begin
        go = 1'h1;
        pick = CW'(i);
      end
    end
  end

  assign cc = ch_cfg[cur_q];
  assign ccnt = ch_cnt[cur_q];
  assign pkt_end = ccnt == 32'h0000_0001 || pkt_off_q == MAX_PKT - 7'h01 || (cc.dir == DIR_RX && last_q);
  assign step = (st_q == ST_MEM && mem_ack_i && !mem_err_i && cc.dir == DIR_RX) ||
                (st_q == ST_TX_PUT && ep_tx_ready_i);
  assign err_set = st_q == ST_MEM && mem_ack_i && mem_err_i;
  // per packet in single mode, only at count zero in multi mode
  assign set_vec = (step && pkt_end && ch_ie[cur_q] && (cc.mode == MODE_SINGLE || ccnt == 32'h0000_0001)) ?
                   NCH'(1) << cur_q : '0;
  // a completion in the reading cycle survives the clear
  assign pend_nx = rd_int ? set_vec : (pend_q | set_vec);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pend_q <= '0;
      irq_o <= 1'h0;
      en_prev_q <= '0;
    end else begin
      pend_q <= pend_nx;
      irq_o <= |pend_nx;
      en_prev_q <= ch_en;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      pkt_off_q <= 7'h00;
      last_q <= 1'h0;
      ep_sel_o <= 4'h0;
      ep_rx_ready_o <= 1'h0;
      ep_tx_valid_o <= 1'h0;
      ep_tx_data_o <= 8'h00;
      ep_tx_last_o <= 1'h0;
      mem_req_o <= 1'h0;
      mem_we_o <= 1'h0;
      mem_addr_o <= RST_WORD;
      mem_wdata_o <= 8'h00;
      mem_burst_o <= BURST_NONE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            cur_q <= pick;
            pkt_off_q <= 7'h00;
            last_q <= 1'h0;
            ep_sel_o <= ch_cfg[pick].ep;
            mem_burst_o <= ch_cfg[pick].burst;
            if (ch_cfg[pick].dir == DIR_RX) begin
              st_q <= ST_RX_GET;
              ep_rx_ready_o <= 1'h1;
            end else begin
              st_q <= ST_MEM;
              mem_req_o <= 1'h1;
              mem_we_o <= 1'h0;
              mem_addr_o <= ch_addr[pick];
            end
          end
        end
        ST_RX_GET: begin
          // a byte offered with ready high is already taken, so it beats a stop
          if (ep_rx_valid_i) begin
            ep_rx_ready_o <= 1'h0;
            last_q <= ep_rx_last_i;
            mem_wdata_o <= ep_rx_data_i;
            mem_req_o <= 1'h1;
            mem_we_o <= 1'h1;
            mem_addr_o <= ch_addr[cur_q];
            st_q <= ST_MEM;
          end else if (!ch_en[cur_q]) begin
            ep_rx_ready_o <= 1'h0;
            st_q <= ST_IDLE;
          end
        end
        ST_MEM: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'h0;
            if (mem_err_i) begin
              st_q <= ST_IDLE;
            end else if (cc.dir == DIR_TX) begin
              ep_tx_data_o <= mem_rdata_i;
              ep_tx_last_o <= pkt_end;
              ep_tx_valid_o <= 1'h1;
              st_q <= ST_TX_PUT;
            end
          end
        end
        ST_TX_PUT: begin
          if (ep_tx_ready_i) begin
            ep_tx_valid_o <= 1'h0;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (step) begin
        pkt_off_q <= pkt_off_q + 7'h01;
        if (pkt_end || !ch_en[cur_q]) begin
          st_q <= ST_IDLE;
        end else if (cc.dir == DIR_RX) begin
          st_q <= ST_RX_GET;
          ep_rx_ready_o <= 1'h1;
        end else begin
          // the channel address moves on at this same edge
          st_q <= ST_MEM;
          mem_req_o <= 1'h1;
          mem_addr_o <= ch_addr[cur_q] + 32'h0000_0001;
        end
      end
    end
  end

  rx_ready_state_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    ep_rx_ready_o |-> st_q == ST_RX_GET && cc.dir == DIR_RX)
    else $error("rx ready outside a receive fetch");

  step_advance_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (step && !wr_cnt && !wr_addr) |=>
      ccnt == $past(ccnt) - 32'h0000_0001 && ch_addr[cur_q] == $past(ch_addr[cur_q]) + 32'h0000_0001)
    else $error("byte step did not move address and count");

  start_enabled_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_q == ST_IDLE ##1 st_q != ST_IDLE) |-> en_prev_q[cur_q])
    else $error("transfer started on a disabled channel");

  ep_bind_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_q == ST_IDLE ##1 st_q != ST_IDLE) |-> ep_sel_o == cc.ep)
    else $error("endpoint select differs from channel setup");

  irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (pend_q & ~$past(pend_q) & ~$past(ch_ie)) == '0)
    else $error("pending bit set with interrupt disabled");

  int_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (rd_int && set_vec == '0) |=> pend_q == '0 && !irq_o)
    else $error("status read did not clear pending bits");

  multi_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (step && cc.mode == MODE_MULTI && ccnt != 32'h0000_0001 && !rd_int) |=> pend_q == $past(pend_q))
    else $error("multi packet mode raised an early completion");

  single_irq_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (step && pkt_end && cc.mode == MODE_SINGLE && ch_ie[cur_q]) |=> pend_q[cur_q] && irq_o)
    else $error("single packet completion not raised");

  mrx_full_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_q == ST_IDLE ##1 st_q == ST_RX_GET && cc.mode == MODE_MULTI) |-> $past(ep_pkt_full_i) != 16'h0000)
    else $error("multi packet receive began without a full packet");

  err_flag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    err_set |=> ch_err[cur_q] && !ch_en[cur_q] && st_q == ST_IDLE)
    else $error("memory error not flagged");
endmodule

// File: bench/udc_far_model.sv
// far side model: endpoint fifos, tx sink and byte memory
`timescale 1ns/1ps
module udc_far_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] avail_i,
  input wire logic [3:0] ep_sel_i,
  output logic rx_vld_o,
  output logic [7:0] rx_dat_o,
  input wire logic rx_rdy_i,
  input wire logic tx_vld_i,
  input wire logic [7:0] tx_dat_i,
  input wire logic tx_last_i,
  output logic tx_rdy_o,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdat_i,
  output logic [7:0] rdat_o,
  output logic ack_o
);
  logic [7:0] mem [256];
  logic [7:0] tx_log [128];
  logic [7:0] rx_n = 8'h00;
  logic [1:0] wait_q = 2'h0;
  int tx_cnt = 0;
  int tx_last_n = 0;
  initial begin
    tx_rdy_o = 1'h0;
    rdat_o = 8'h00;
    ack_o = 1'h0;
  end
  // only the selected endpoint offers data; idle lines show flipped junk
  assign rx_vld_o = avail_i[ep_sel_i];
  assign rx_dat_o = rx_vld_o ? 8'hA0 + rx_n : ~(8'hA0 + rx_n);
  always @(posedge clk_sys_i) begin
    tx_rdy_o <= ~tx_rdy_o;
    ack_o <= 1'h0;
    rdat_o <= ~rdat_o;
    if (rx_vld_o && rx_rdy_i) rx_n <= rx_n + 8'h01;
    // wait count cycles so some requests answer at once, others late
    if (req_i && !ack_o) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q[1]) begin
        ack_o <= 1'h1;
        rdat_o <= mem[addr_i[7:0]];
        if (we_i) mem[addr_i[7:0]] <= wdat_i;
      end
    end
    if (tx_vld_i && tx_rdy_o) begin
      tx_log[tx_cnt] <= tx_dat_i;
      tx_cnt <= tx_cnt + 1;
      if (tx_last_i) tx_last_n <= tx_last_n + 1;
    end
  end
endmodule

// File: bench/usb_integrated_dma_channels_tb_top.sv
// self-checking bench for the usb dma channel engine
`timescale 1ns/1ps
module usb_integrated_dma_channels_tb_top import udc_pkg::*;
;
  logic clk = 1'h0;
  logic nrst = 1'h0, awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, d, madr, rdata;
  logic [15:0] avail = 16'h0, full = 16'h0;
  logic merr = 1'h0, txl;
  logic awr, wr, bv, arr, rv, rxv, rxr, txv, txr, mreq, mwe, mack, irq;
  logic [1:0] bresp, rresp, br, rsp, mburst;
  logic [7:0] rxd, txd, mwd, mrd;
  logic [3:0] sel;
  logic [7:0] cfg_q [4];
  logic [31:0] cnt_q [4];
  int err_total = 0, check_count = 0, seed = 70654;
  always #25 clk = ~clk;
  udc_top dut_u (.clk_sys_i(clk), .nrst_i(nrst),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(brd), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .ep_sel_o(sel), .ep_rx_avail_i(avail), .ep_pkt_full_i(full),
    .ep_rx_valid_i(rxv), .ep_rx_data_i(rxd), .ep_rx_last_i(1'h0), .ep_rx_ready_o(rxr),
    .ep_tx_valid_o(txv), .ep_tx_data_o(txd), .ep_tx_last_o(txl), .ep_tx_ready_i(txr),
    .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(madr), .mem_wdata_o(mwd), .mem_burst_o(mburst),
    .mem_rdata_i(mrd), .mem_ack_i(mack), .mem_err_i(merr), .irq_o(irq));
  udc_far_model far_u (.clk_sys_i(clk), .avail_i(avail), .ep_sel_i(sel), .rx_vld_o(rxv),
    .rx_dat_o(rxd), .rx_rdy_i(rxr), .tx_vld_i(txv), .tx_dat_i(txd), .tx_last_i(txl), .tx_rdy_o(txr),
    .req_i(mreq), .we_i(mwe), .addr_i(madr), .wdat_i(mwd), .rdat_o(mrd), .ack_o(mack));
  task automatic test_done;
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic to;
    err_total++;
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // trailing edge keeps a release and the next raise out of one time step
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic pend;
    awa <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    brd <= 1'h1;
    pend = 1'h1;
    for (n = 0; n < 200 && pend; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
      if (bv) begin
        pend = 1'h0;
        br = bresp;
        brd <= 1'h0;
      end
    end
    if (pend) to();
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    logic pend;
    ara <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    pend = 1'h1;
    for (n = 0; n < 200 && pend; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      if (rv) begin
        pend = 1'h0;
        d = rdata;
        rsp = rresp;
        rrd <= 1'h0;
      end
    end
    if (pend) to();
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    axr(a);
    chk(nm, e, d);
  endtask
  task automatic wirq;
    int n;
    for (n = 0; n < 3000 && irq !== 1'h1; n++) @(posedge clk);
    if (n == 3000) to();
  endtask
  initial begin
    for (int i = 0; i < 256; i++) far_u.mem[i] = 8'h5A ^ 8'(i);
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    rc(REG_NUM, NUM_CH, "num");
    axr(8'h20);
    chk("rresp", 32'(RESP_SLVERR), 32'(rsp));
    axw(8'h20, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(br));
    for (int c = 0; c < 4; c++) begin
      cnt_q[c] = c[0] ? 32'(($random(seed) & 7) + 1) : 32'h46;
      cfg_q[c] = {4'(c + 1), 2'(c), c == 0, c == 0};
      axw(REG_SEL, 32'(c));
      axw(REG_CFG, {24'h0, cfg_q[c]});
      axw(REG_ADDR, 32'(c * 64));
      axw(REG_CNT, cnt_q[c]);
    end
    for (int c = 0; c < 4; c++) begin
      axw(REG_SEL, 32'(c));
      rc(REG_CFG, {24'h0, cfg_q[c]}, "cfg");
      // address readback is fine: this controller is past its earliest revision
      rc(REG_ADDR, 32'(c * 64), "addr");
      rc(REG_CNT, cnt_q[c], "count");
    end
    axw(REG_CTRL, 32'h1 << CTL_EN);
    axw(REG_SEL, 32'h1);
    axw(REG_CTRL, 32'h1 << CTL_EN);
    axw(REG_CTRL, 32'h1 << CTL_DIS);
    rc(REG_CFG, {24'h0, cfg_q[1]}, "dis");
    rc(REG_CNT, cnt_q[1], "idle_cnt");
    axw(REG_SEL, 32'h3);
    rc(REG_CFG, {22'h0, 2'h2, cfg_q[3]}, "other_en");
    axw(REG_CTRL, 32'h1 << CTL_DIS);
    avail <= 16'h0008;
    axw(REG_SEL, 32'h2);
    axw(REG_CFG, {22'h0, 2'h3, cfg_q[2]});
    wirq();
    chk("rx_pkt", 32'h40, 32'(far_u.rx_n));
    chk("rx_burst", 32'(cfg_q[2][3:2]), 32'(mburst));
    rc(REG_INT, 32'h4, "int");
    rc(REG_INT, 32'h0, "int_clr");
    wirq();
    chk("rx_all", 32'h46, 32'(far_u.rx_n));
    rc(REG_INT, 32'h4, "int2");
    rc(REG_CNT, 32'h0, "rx_cnt");
    rc(REG_ADDR, 32'hC6, "rx_addr");
    rc(REG_CFG, {22'h0, 2'h1, cfg_q[2]}, "rx_done");
    for (int i = 0; i < 70; i++) chk("rx_mem", 32'(8'hA0 + 8'(i)), 32'(far_u.mem[128 + i]));
    avail <= 16'h0000;
    axw(REG_SEL, 32'h0);
    axw(REG_CFG, {22'h0, 2'h3, cfg_q[0]});
    wirq();
    chk("tx_all", 32'h46, 32'(far_u.tx_cnt));
    chk("tx_burst", 32'(cfg_q[0][3:2]), 32'(mburst));
    chk("tx_last", 32'((32'h46 + 32'(MAX_PKT) - 32'h1) / 32'(MAX_PKT)), 32'(far_u.tx_last_n));
    rc(REG_INT, 32'h1, "int_tx");
    for (int i = 0; i < 70; i++) chk("tx_data", 32'(8'h5A ^ 8'(i)), 32'(far_u.tx_log[i]));
    // multi receive, interrupt off: data waiting alone must not start it
    avail <= 16'h0010;
    axw(REG_SEL, 32'h3);
    axw(REG_CFG, {22'h0, 2'h2, cfg_q[3][7:2], MODE_MULTI, DIR_RX});
    rc(REG_CNT, cnt_q[3], "mrx_hold");
    full <= 16'h0010;
    repeat (60) @(posedge clk);
    rc(REG_CNT, 32'h0, "mrx_cnt");
    chk("mrx_n", 32'h46 + cnt_q[3], 32'(far_u.rx_n));
    chk("mrx_burst", 32'(cfg_q[3][3:2]), 32'(mburst));
    rc(REG_INT, 32'h0, "ie_off");
    // memory error on the first byte of channel 1
    avail <= 16'h0004;
    merr <= 1'h1;
    axw(REG_SEL, 32'h1);
    axw(REG_CTRL, 32'h1 << CTL_EN);
    repeat (10) @(posedge clk);
    rc(REG_STAT, 32'h1, "err");
    rc(REG_CFG, {24'h0, cfg_q[1]}, "err_stop");
    rc(REG_CNT, cnt_q[1], "err_cnt");
    axw(REG_STAT, 32'h1);
    rc(REG_STAT, 32'h0, "err_clr");
    test_done();
  end
endmodule
